// [iac_pkg.sv]
// Shared constants and types for the interrupt and idle controller
package iac_pkg;
  localparam int          NUM_SRC       = 12;
  localparam int          IDX_W         = $clog2(NUM_SRC);
  localparam int          GLOBAL_EN_BIT = 7;
  localparam int          EN_SRC_CNT    = 7;
  localparam int          EIE_SRC_CNT   = NUM_SRC - EN_SRC_CNT;
  localparam int          IDLE_BIT      = 0;
  localparam int          STOP_BIT      = 1;
  localparam logic [7:0]  EN_RESET      = 8'h00;
  localparam logic [7:0]  EIE_RESET     = 8'h00;
  localparam logic [1:0]  PWR_RESET     = 2'h0;
  localparam logic [11:0] PEND_RESET    = 12'h000;
  localparam logic [11:0] PRIO_RESET    = 12'h000;
  localparam logic [11:0] AUTO_CLR_DEF  = 12'h000;
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [15:0] VEC_STRIDE    = 16'h0008;

  typedef enum logic [1:0] {IAC_RUN, IAC_IDLE, IAC_STOP} iac_mode_type;
endpackage : iac_pkg

// [iac_arb_if.sv]
// Request vectors and arbitration result between controller and arbiter
`timescale 1ns/100ps
`default_nettype none
interface iac_arb_if #(parameter int N = 12, parameter int W = 4);
  logic [N-1:0] req_hi;
  logic [N-1:0] req_lo;
  logic         found;
  logic         found_hi;
  logic [W-1:0] idx;
  modport ctrl (output req_hi, output req_lo, input found, input found_hi, input idx);
  modport arb  (input req_hi, input req_lo, output found, output found_hi, output idx);
endinterface : iac_arb_if
`default_nettype wire

// [iac_arbiter.sv]
// Two-level fixed-order request picker
`timescale 1ns/100ps
`default_nettype none
module iac_arbiter #(
  parameter int N = 12,
  parameter int W = 4
) (
  iac_arb_if.arb a
);
  generate
    if (N < 2 || (1 << W) < N) begin : g_bad
      $error("iac_arbiter: index width too small for source count");
    end
  endgenerate

  logic [N-1:0] sel;

  // High level always beats low; lowest index wins inside a level
  always_comb begin
    sel        = (|a.req_hi) ? a.req_hi : a.req_lo;
    a.found    = |sel;
    a.found_hi = |a.req_hi;
    a.idx      = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel[i]) begin
        a.idx = i[W-1:0];
      end
    end
  end
endmodule : iac_arbiter
`default_nettype wire

// [iac_ctrl.sv]
// Interrupt pending, enable, vectoring and power-mode control
// Function
// - Twelve request sources, arbitrated over two priority levels.
// - A detected source condition sets its pending flag regardless of enable.
// - Enabled pending flag vectors with a long call after the current instruction.
// - Return from service resumes the instruction that would have run next.
// - Pending flag of a disabled source makes no request.
// - Each source has its own enable; all gated by the global enable bit 7.
// - Global enable at zero blocks every source.
// - Request posted while global enable clears may go only before a single-cycle instruction.
// - Only selected flags clear on vectoring; software clears the rest.
// - Flag still set after return re-enters after one more instruction.
// - Software writing a pending flag to one acts as a hardware request.
// - Idle select bit halts the core after the setting instruction completes.
// - Stop mode halts core and clock; interrupts and timers inactive.
// - Enabled request or reset ends idle; request clears idle select bit.
// - After an idle wake service, execution continues after the idle-setting instruction.
// - Reset ending idle runs the normal reset and starts at address zero.
// - Watchdog expiry during idle gives an internal reset that ends idle.
// - With oscillators stopped only a reset restarts the controller.
`timescale 1ns/100ps
`default_nettype none
module iac_ctrl #(
  parameter logic [11:0] AUTO_CLEAR_MASK = iac_pkg::AUTO_CLR_DEF
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] src_event,
  input  wire logic        pend_we,
  input  wire logic [11:0] pend_wdata,
  input  wire logic        en_we,
  input  wire logic [7:0]  en_wdata,
  input  wire logic        eie_we,
  input  wire logic [7:0]  eie_wdata,
  input  wire logic        prio_we,
  input  wire logic [11:0] prio_wdata,
  input  wire logic        pwr_we,
  input  wire logic [1:0]  pwr_wdata,
  input  wire logic        instr_done,
  input  wire logic        instr_single,
  input  wire logic        ret_done,
  input  wire logic        wdog_expire,
  output logic      [11:0] pend_flags,
  output logic      [7:0]  int_enable_reg,
  output logic      [7:0]  ext_int_enable_reg,
  output logic      [11:0] prio_reg,
  output logic      [1:0]  power_control_reg,
  output logic             vec_req,
  output logic      [15:0] vec_addr,
  output logic      [3:0]  vec_src,
  output logic             vec_hi,
  output logic             vec_from_idle,
  output logic             core_halt,
  output logic             clk_stop,
  output logic             restart_req,
  output logic             act_hi,
  output logic             act_lo
);
  localparam int N = iac_pkg::NUM_SRC;
  localparam int W = iac_pkg::IDX_W;

  generate
    if (iac_pkg::EN_SRC_CNT > iac_pkg::GLOBAL_EN_BIT || iac_pkg::EIE_SRC_CNT > 8) begin : g_bad
      $error("iac_ctrl: sources do not fit the enable registers");
    end
  endgenerate

  iac_arb_if #(.N(N), .W(W)) arb ();
  iac_arbiter #(.N(N), .W(W)) u_arb (.a(arb));

  iac_pkg::iac_mode_type mode;
  iac_pkg::iac_mode_type next_mode;

  // Watchdog expiry is folded into the reset: same effect as the pin
  logic          sys_reset;
  logic [N-1:0]  en_vec;
  logic          glob_en;
  logic [N-1:0]  cand;
  logic          take_now;
  logic          take_posted;
  logic          take;
  logic [W-1:0]  sel_idx;
  logic          sel_hi;
  logic          posted_valid;
  logic [W-1:0]  posted_idx;
  logic          posted_hi;
  logic          in_stop;
  logic [N-1:0]  next_pend;

  assign sys_reset = !rstn || wdog_expire;
  assign en_vec    = {ext_int_enable_reg[iac_pkg::EIE_SRC_CNT-1:0],
                      int_enable_reg[iac_pkg::EN_SRC_CNT-1:0]};
  assign glob_en   = int_enable_reg[iac_pkg::GLOBAL_EN_BIT];
  assign cand      = pend_flags & en_vec & {N{glob_en}};
  assign in_stop   = (mode == iac_pkg::IAC_STOP);

  // Levels allowed given the routines already running
  assign arb.req_hi = act_hi ? '0 : (cand & prio_reg);
  assign arb.req_lo = (act_hi || act_lo) ? '0 : (cand & ~prio_reg);

  // The return instruction's own boundary never vectors, so one more runs
  assign take_now    = arb.found && !in_stop &&
                       ((mode == iac_pkg::IAC_RUN && instr_done && !ret_done) ||
                        mode == iac_pkg::IAC_IDLE);
  // Request seen before the global enable dropped survives a single-cycle op only
  assign take_posted = !arb.found && posted_valid && pend_flags[posted_idx] &&
                       mode == iac_pkg::IAC_RUN && instr_done && instr_single &&
                       !ret_done;
  assign take        = take_now || take_posted;
  assign sel_idx     = take_now ? arb.idx : posted_idx;
  assign sel_hi      = take_now ? arb.found_hi : posted_hi;

  // Posted request lives for exactly one instruction boundary
  always_ff @(posedge clk) begin
    if (sys_reset) begin
      posted_valid <= 1'b0;
      posted_idx   <= '0;
      posted_hi    <= 1'b0;
    end else if (instr_done) begin
      posted_valid <= arb.found && !take;
      posted_idx   <= arb.idx;
      posted_hi    <= arb.found_hi;
    end
  end

  // Pending flags: software write, then auto clear, then hardware set wins
  always_comb begin
    next_pend = pend_flags;
    if (pend_we) begin
      next_pend = pend_wdata;
    end
    if (take && AUTO_CLEAR_MASK[sel_idx]) begin
      next_pend[sel_idx] = 1'b0;
    end
    if (!in_stop) begin
      next_pend = next_pend | src_event;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_reset) begin
      pend_flags <= iac_pkg::PEND_RESET;
    end else begin
      pend_flags <= next_pend;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_reset) begin
      int_enable_reg     <= iac_pkg::EN_RESET;
      ext_int_enable_reg <= iac_pkg::EIE_RESET;
      prio_reg           <= iac_pkg::PRIO_RESET;
    end else begin
      if (en_we) begin
        int_enable_reg <= en_wdata;
      end
      if (eie_we) begin
        ext_int_enable_reg <= eie_wdata;
      end
      if (prio_we) begin
        prio_reg <= prio_wdata;
      end
    end
  end

  // Service nesting; a return closes the most recent level
  always_ff @(posedge clk) begin
    if (sys_reset) begin
      act_hi <= 1'b0;
      act_lo <= 1'b0;
    end else if (take) begin
      if (sel_hi) begin
        act_hi <= 1'b1;
      end else begin
        act_lo <= 1'b1;
      end
    end else if (ret_done) begin
      if (act_hi) begin
        act_hi <= 1'b0;
      end else begin
        act_lo <= 1'b0;
      end
    end
  end

  // Power modes; stop is left only through reset, as the clock is gone
  always_comb begin
    next_mode = mode;
    case (mode)
      iac_pkg::IAC_RUN: begin
        if (instr_done && !take && power_control_reg[iac_pkg::STOP_BIT]) begin
          next_mode = iac_pkg::IAC_STOP;
        end else if (instr_done && !take && power_control_reg[iac_pkg::IDLE_BIT]) begin
          next_mode = iac_pkg::IAC_IDLE;
        end
      end
      iac_pkg::IAC_IDLE: begin
        if (take) begin
          next_mode = iac_pkg::IAC_RUN;
        end
      end
      iac_pkg::IAC_STOP: begin
        next_mode = iac_pkg::IAC_STOP;
      end
      default: begin
        next_mode = iac_pkg::IAC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_reset) begin
      mode      <= iac_pkg::IAC_RUN;
      core_halt <= 1'b0;
      clk_stop  <= 1'b0;
    end else begin
      mode      <= next_mode;
      core_halt <= (next_mode != iac_pkg::IAC_RUN);
      clk_stop  <= (next_mode == iac_pkg::IAC_STOP);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_reset) begin
      power_control_reg <= iac_pkg::PWR_RESET;
    end else if (mode == iac_pkg::IAC_IDLE && take) begin
      power_control_reg[iac_pkg::IDLE_BIT] <= 1'b0;
    end else if (mode == iac_pkg::IAC_STOP) begin
      power_control_reg <= power_control_reg;
    end else if (pwr_we) begin
      power_control_reg <= pwr_wdata;
    end else if (mode == iac_pkg::IAC_IDLE) begin
      power_control_reg <= power_control_reg;
    end
  end

  // Vector issue; the core stacks its next address, so idle wake resumes in line
  always_ff @(posedge clk) begin
    if (sys_reset) begin
      vec_req       <= 1'b0;
      vec_addr      <= iac_pkg::RESET_VECTOR;
      vec_src       <= 4'h0;
      vec_hi        <= 1'b0;
      vec_from_idle <= 1'b0;
      restart_req   <= 1'b1;
    end else begin
      restart_req <= 1'b0;
      vec_req     <= take;
      if (take) begin
        vec_addr      <= iac_pkg::VEC_BASE + 16'(sel_idx) * iac_pkg::VEC_STRIDE;
        vec_src       <= 4'(sel_idx);
        vec_hi        <= sel_hi;
        vec_from_idle <= (mode == iac_pkg::IAC_IDLE);
      end
    end
  end

  a_pend_sets: assert property (@(posedge clk) disable iff (!rstn)
    ((|src_event) && !in_stop && !wdog_expire) |=>
      ((pend_flags & $past(src_event)) == $past(src_event)))
    else $error("pending flag not set by source event");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (cand == '0 && !posted_valid) |=> !vec_req)
    else $error("vector with no enabled pending source");
  a_glob_off: assert property (@(posedge clk) disable iff (!rstn)
    (!glob_en && !posted_valid) |=> !vec_req)
    else $error("vector while global enable is off");
  a_vec_boundary: assert property (@(posedge clk) disable iff (!rstn)
    vec_req |-> ($past(instr_done) || $past(mode) == iac_pkg::IAC_IDLE))
    else $error("vector not at instruction boundary");
  a_vec_address: assert property (@(posedge clk) disable iff (!rstn)
    vec_req |-> vec_addr == iac_pkg::VEC_BASE + 16'(vec_src) * iac_pkg::VEC_STRIDE)
    else $error("vector address does not match source");
  a_ret_defer: assert property (@(posedge clk) disable iff (!rstn || wdog_expire)
    ret_done && mode == iac_pkg::IAC_RUN |=> !vec_req)
    else $error("vector on the return boundary itself");
  a_idle_entry: assert property (@(posedge clk) disable iff (sys_reset)
    (mode == iac_pkg::IAC_RUN && instr_done && !take &&
     power_control_reg == 2'h1) |=> core_halt ##1 (core_halt || vec_req))
    else $error("idle select did not halt core");
  a_idle_wake: assert property (@(posedge clk) disable iff (sys_reset)
    (mode == iac_pkg::IAC_IDLE && arb.found) |=>
      (vec_req && vec_from_idle && !core_halt &&
       !power_control_reg[iac_pkg::IDLE_BIT]))
    else $error("enabled request did not end idle");
  a_stop_hold: assert property (@(posedge clk) disable iff (sys_reset)
    clk_stop |=> clk_stop && !vec_req)
    else $error("stop left without reset");
  a_preempt: assert property (@(posedge clk) disable iff (sys_reset)
    (vec_req && vec_hi) |-> !$past(act_hi))
    else $error("high vector while high routine active");
  a_reset_vec: assert property (@(posedge clk)
    (!rstn || wdog_expire) |=>
      restart_req && vec_addr == iac_pkg::RESET_VECTOR && !core_halt)
    else $error("reset did not restart at address zero");
endmodule : iac_ctrl
`default_nettype wire

// [iac_core_model.sv]
// Core model that retires instructions and returns from service routines
`timescale 1ns/100ps
`default_nettype none
module iac_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic single,
  input  wire logic ret_cmd,
  input  wire logic core_halt,
  input  wire logic clk_stop,
  output logic      instr_done,
  output logic      instr_single,
  output logic      ret_done
);
  logic [1:0] cnt;
  logic       fire;
  // Four-cycle instructions; a halted core retires nothing
  assign fire = run && !core_halt && !clk_stop && (cnt == 2'h3);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt          <= 2'h0;
      instr_done   <= 1'b0;
      instr_single <= 1'b0;
      ret_done     <= 1'b0;
    end else begin
      cnt          <= cnt + 2'h1;
      instr_done   <= fire;
      // Software picks the next instruction length
      instr_single <= single;
      // Bench clears flags before asking for the return
      ret_done     <= fire && ret_cmd;
    end
  end
endmodule : iac_core_model
`default_nettype wire

// [interrupt_and_idle_control_bench.sv]
// Self-checking bench for the interrupt and idle controller
`timescale 1ns/100ps
`default_nettype none
module interrupt_and_idle_control_bench;
  localparam logic [2:0] SEL_PND = 3'h0;
  localparam logic [2:0] SEL_ENA = 3'h1;
  localparam logic [2:0] SEL_EXT = 3'h2;
  localparam logic [2:0] SEL_PRI = 3'h3;
  localparam logic [2:0] SEL_PWR = 3'h4;
  // Source 11 is cleared by hardware on vectoring, the rest by software
  localparam logic [11:0] AUTO_CLR = 12'h800;
  logic        clk, rstn, pend_we, en_we, eie_we, prio_we, pwr_we;
  logic        run, single, ret_cmd, wdog_expire, instr_done, instr_single;
  logic        ret_done, vec_req, vec_hi, vec_from_idle, core_halt;
  logic        clk_stop, restart_req, act_hi, act_lo;
  logic [11:0] src_event, pend_wdata, prio_wdata, pend_flags, prio_reg;
  logic [7:0]  en_wdata, eie_wdata, int_enable_reg, ext_int_enable_reg;
  logic [1:0]  pwr_wdata, power_control_reg;
  logic [15:0] vec_addr;
  logic [3:0]  vec_src;
  int          n_errors, tests_run;

  iac_ctrl #(.AUTO_CLEAR_MASK(AUTO_CLR)) dut_u (.clk, .rstn, .src_event, .pend_we,
    .pend_wdata, .en_we, .en_wdata, .eie_we, .eie_wdata, .prio_we, .prio_wdata, .pwr_we,
    .pwr_wdata, .instr_done, .instr_single, .ret_done, .wdog_expire, .pend_flags,
    .int_enable_reg,
    .ext_int_enable_reg, .prio_reg, .power_control_reg, .vec_req, .vec_addr, .vec_src,
    .vec_hi, .vec_from_idle, .core_halt, .clk_stop, .restart_req, .act_hi, .act_lo);
  iac_core_model core_u (.clk, .rstn, .run, .single, .ret_cmd, .core_halt, .clk_stop,
    .instr_done, .instr_single, .ret_done);

  always #2.5 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] sel, input logic [11:0] d);
    pend_wdata = d;
    prio_wdata = d;
    en_wdata = d[7:0];
    eie_wdata = d[7:0];
    pwr_wdata = d[1:0];
    {pwr_we, prio_we, eie_we, en_we, pend_we} = 5'h01 << sel;
    tick(1);
    // Strobes rest a cycle so back-to-back calls never touch them twice at once
    {pwr_we, prio_we, eie_we, en_we, pend_we} = 5'h00;
    tick(1);
  endtask : wr

  // Waits for the long call and checks where it goes
  task automatic wait_vec(input int s, input logic hi, input logic idle);
    repeat (40) if (vec_req !== 1'b1) tick(1);
    check("vec_req", vec_req, 16'h0001);
    check("vec_addr", vec_addr, iac_pkg::VEC_BASE + iac_pkg::VEC_STRIDE * 16'(s));
    check("vec_src", vec_src, 16'(s));
    check("vec_hi", vec_hi, hi);
    check("vec_from_idle", vec_from_idle, idle);
    tick(1);
  endtask : wait_vec

  // Flags must be cleared before the return, or the routine runs again
  task automatic ret_clr(input logic [11:0] keep);
    wr(SEL_PND, keep);
    ret_cmd = 1'b1;
    repeat (40) if (ret_done !== 1'b1) tick(1);
    ret_cmd = 1'b0;
    tick(1);
  endtask : ret_clr

  task automatic halt_wait(input logic [11:0] mode);
    wr(SEL_PWR, mode);
    repeat (20) if (core_halt !== 1'b1) tick(1);
    check("core_halt", core_halt, 16'h0001);
  endtask : halt_wait

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #30000;
    n_errors++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    src_event = '0;
    wdog_expire = 1'b0;
    run = 1'b1;
    single = 1'b0;
    ret_cmd = 1'b0;
    {pwr_we, prio_we, eie_we, en_we, pend_we} = 5'h00;
    {pend_wdata, prio_wdata, en_wdata, eie_wdata, pwr_wdata} = '0;
    n_errors = 0;
    tests_run = 0;
    tick(4);
    check("restart_req", restart_req, 16'h0001);
    check("vec_addr", vec_addr, iac_pkg::RESET_VECTOR);
    rstn = 1;
    tick(2);
    check("pend_flags", pend_flags, iac_pkg::PEND_RESET);
    $display("test reset done");
    // Flag is set but no call while either enable is missing
    src_event = 12'h004;
    tick(1);
    src_event = 12'h000;
    check("pend_flags", pend_flags, 12'h004);
    for (int k = 0; k < 2; k++) begin
      wr(SEL_ENA, k ? 12'h004 : 12'h080);
      repeat (10) begin
        tick(1);
        check("vec_req", vec_req, 16'h0000);
      end
    end
    wr(SEL_ENA, 12'h084);
    wait_vec(2, 0, 0);
    check("act_lo", act_lo, 16'h0001);
    ret_clr(0);
    check("act_lo", act_lo, 16'h0000);
    $display("test enables done");
    wr(SEL_ENA, 12'h0ff);
    wr(SEL_EXT, 12'h01f);
    check("ext_int_enable_reg", ext_int_enable_reg, 16'h001f);
    for (int i = 0; i < 12; i++) begin
      wr(SEL_PND, 12'h001 << i);
      wait_vec(i, 0, 0);
      check("pend_flags", pend_flags, AUTO_CLR[i] ? 16'h0000 : 16'h0001 << i);
      ret_clr(0);
    end
    $display("test sources done");
    wr(SEL_PRI, 12'h020);
    check("prio_reg", prio_reg, 16'h0020);
    wr(SEL_PND, 12'h021);
    wait_vec(5, 1, 0);
    tick(12);
    check("act_lo", act_lo, 16'h0000);
    ret_clr(12'h001);
    wait_vec(0, 0, 0);
    wr(SEL_PND, 12'h021);
    wait_vec(5, 1, 0);
    check("act_lo", act_lo, 16'h0001);
    ret_clr(0);
    check("act_hi", act_hi, 16'h0000);
    check("act_lo", act_lo, 16'h0001);
    ret_clr(0);
    check("act_lo", act_lo, 16'h0000);
    // High request lands in the return instruction, then global enable drops
    for (int k = 0; k < 2; k++) begin
      wr(SEL_PND, 12'h000);
      wr(SEL_ENA, 12'h0ff);
      wr(SEL_PND, 12'h001);
      wait_vec(0, 0, 0);
      repeat (8) if (instr_done !== 1'b1) tick(1);
      ret_cmd = 1'b1;
      wr(SEL_PND, 12'h020);
      repeat (40) if (ret_done !== 1'b1) tick(1);
      ret_cmd = 1'b0;
      single = k[0];
      wr(SEL_ENA, 12'h07f);
      if (k == 1) begin
        wait_vec(5, 1, 0);
      end else begin
        repeat (12) begin
          tick(1);
          check("vec_req", vec_req, 16'h0000);
        end
      end
      check("int_enable_reg", int_enable_reg, 16'h007f);
      single = 1'b0;
    end
    ret_clr(0);
    wr(SEL_ENA, 12'h0ff);
    $display("test posted done");
    wr(SEL_PRI, 12'h000);
    $display("test priority done");
    halt_wait(12'h001);
    check("int_enable_reg", int_enable_reg, 16'h00ff);
    tick(6);
    src_event = 12'h008;
    tick(1);
    src_event = 12'h000;
    wait_vec(3, 0, 1);
    check("core_halt", core_halt, 16'h0000);
    check("power_control_reg", power_control_reg, 16'h0000);
    ret_clr(0);
    halt_wait(12'h001);
    wdog_expire = 1'b1;
    tick(1);
    wdog_expire = 1'b0;
    check("restart_req", restart_req, 16'h0001);
    check("core_halt", core_halt, 16'h0000);
    check("int_enable_reg", int_enable_reg, iac_pkg::EN_RESET);
    tick(2);
    $display("test idle done");
    wr(SEL_ENA, 12'h088);
    halt_wait(12'h002);
    check("clk_stop", clk_stop, 16'h0001);
    src_event = 12'h008;
    tick(1);
    src_event = 12'h000;
    tick(1);
    check("pend_flags", pend_flags, 16'h0000);
    wr(SEL_PWR, 12'h000);
    check("power_control_reg", power_control_reg, 16'h0002);
    rstn = 0;
    tick(1);
    rstn = 1;
    tick(1);
    check("clk_stop", clk_stop, 16'h0000);
    $display("test stop done");
    end_of_test();
  end
endmodule : interrupt_and_idle_control_bench
`default_nettype wire
